/* File: rtl/tgc_gate_select.v */
`timescale 1ns/100ps
`include "tgc_consts.vh"

module tgc_gate_select #(
  parameter INSTANCE = 1
) (
  input  wire        clock,
  input  wire        nrst,
  // axi4-lite slave
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // gate sources
  input  wire        remappableGatePin,
  input  wire        baseTimerOvf,
  input  wire [2:0]  gatedTimerOvf,
  input  wire [2:0]  periodTimerPostscaled,
  input  wire        signalMeasureOverflow,
  input  wire [3:0]  captureCompareOut,
  input  wire [1:0]  pwmUnitOut,
  input  wire        numericOscillatorOut,
  input  wire [1:0]  comparatorSyncOut,
  input  wire        zeroCrossOut,
  input  wire [3:0]  logicCellOut,
  // clock sources
  input  wire        remappableClockPin,
  input  wire        instrClock,
  input  wire        sysClock,
  input  wire        highFreqInternalOsc,
  input  wire        lowFreqInternalOsc,
  input  wire        midFreqInternalOsc500k,
  input  wire        midFreqInternalOsc32k,
  input  wire        secondaryOscillator,
  input  wire        referenceClockOut,
  // to the counter
  output reg         timerGateEnable,
  output reg         countClock,
  output reg         irq
);

  localparam SP_IDLE = 2'h0;
  localparam SP_ARMED = 2'h1;
  localparam SP_OPEN = 2'h2;

  // reset release through two flops
  reg rstMeta_reg;
  reg rstN_reg;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstMeta_reg <= 1'b0;
      rstN_reg    <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstN_reg    <= rstMeta_reg;
    end
  end

  // byte address to register index; unaligned addresses fall off the map
  function [12:0] addrIndex;
    input [11:0] addr;
    begin
      addrIndex = (addr[1:0] == 2'h0) ? {3'h0, addr[11:2]} : 13'h1FFF;
    end
  endfunction

  function isMapped;
    input [12:0] idx;
    begin
      if (idx == {1'b0, `TGC_IDX_TIMER_CTRL}) isMapped = 1'b1;
      else if (idx == {1'b0, `TGC_IDX_GATE_CTRL}) isMapped = 1'b1;
      else if (idx == {1'b0, `TGC_IDX_GATE_SRC}) isMapped = 1'b1;
      else if (idx == {1'b0, `TGC_IDX_CLK_SRC}) isMapped = 1'b1;
      else if (idx == {1'b0, `TGC_IDX_IRQ_STATUS}) isMapped = 1'b1;
      else if (idx == {1'b0, `TGC_IDX_IRQ_MASK}) isMapped = 1'b1;
      else isMapped = 1'b0;
    end
  endfunction

  // software state
  reg        timerOn_reg;
  reg        gateEnable_reg;
  reg        gatePolarity_reg;
  reg        gateToggleMode_reg;
  reg        gateSinglePulseMode_reg;
  reg        singlePulseGoDone_reg;
  reg [4:0]  gateSourceCode_reg;
  reg [4:0]  clockSourceCode_reg;
  reg [1:0]  irqStatus_reg;
  reg [1:0]  irqMask_reg;

  // gate path state
  reg        toggleFf_reg;
  reg        gatePrev_reg;
  reg [1:0]  spState_reg;
  reg        gateLive_reg;

  // write channel holding
  reg        awHeld_reg;
  reg        wHeld_reg;
  reg [11:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg        wLane0_reg;

  // gate source mux; reserved and own-overflow codes drive rawGate low
  wire [4:0] gate_source_code = gateSourceCode_reg;
  reg        rawGate;
  always @* begin
    case (gate_source_code)
      `TGC_GS_PIN:      rawGate = remappableGatePin;
      `TGC_GS_BASE_OVF: rawGate = baseTimerOvf;
      `TGC_GS_PT1_POST: rawGate = periodTimerPostscaled[0];
      `TGC_GS_PT2_POST: rawGate = periodTimerPostscaled[1];
      `TGC_GS_PT3_POST: rawGate = periodTimerPostscaled[2];
      `TGC_GS_GT1_OVF:  rawGate = (INSTANCE != 1) & gatedTimerOvf[0];
      `TGC_GS_GT2_OVF:  rawGate = (INSTANCE != 2) & gatedTimerOvf[1];
      `TGC_GS_GT3_OVF:  rawGate = (INSTANCE != 3) & gatedTimerOvf[2];
      `TGC_GS_SMT_OVF:  rawGate = signalMeasureOverflow;
      `TGC_GS_CCP1:     rawGate = captureCompareOut[0];
      `TGC_GS_CCP2:     rawGate = captureCompareOut[1];
      `TGC_GS_CCP3:     rawGate = captureCompareOut[2];
      `TGC_GS_CCP4:     rawGate = captureCompareOut[3];
      `TGC_GS_PWM1:     rawGate = pwmUnitOut[0];
      `TGC_GS_PWM2:     rawGate = pwmUnitOut[1];
      `TGC_GS_NCO:      rawGate = numericOscillatorOut;
      `TGC_GS_CMP1:     rawGate = comparatorSyncOut[0];
      `TGC_GS_CMP2:     rawGate = comparatorSyncOut[1];
      `TGC_GS_ZCD:      rawGate = zeroCrossOut;
      `TGC_GS_LC1:      rawGate = logicCellOut[0];
      `TGC_GS_LC2:      rawGate = logicCellOut[1];
      `TGC_GS_LC3:      rawGate = logicCellOut[2];
      `TGC_GS_LC4:      rawGate = logicCellOut[3];
      default:          rawGate = 1'b0;
    endcase
  end

  // clock source mux; reserved codes hold the clock low so nothing counts
  reg selClock;
  always @* begin
    case (clockSourceCode_reg)
      `TGC_CS_PIN:      selClock = remappableClockPin;
      `TGC_CS_INSTR:    selClock = instrClock;
      `TGC_CS_SYS:      selClock = sysClock;
      `TGC_CS_HFOSC:    selClock = highFreqInternalOsc;
      `TGC_CS_LFOSC:    selClock = lowFreqInternalOsc;
      `TGC_CS_MF500K:   selClock = midFreqInternalOsc500k;
      `TGC_CS_MF32K:    selClock = midFreqInternalOsc32k;
      `TGC_CS_SECONDARY_OSCILLATOR:     selClock = secondaryOscillator;
      `TGC_CS_REFCLK:   selClock = referenceClockOut;
      `TGC_CS_BASE_OVF: selClock = baseTimerOvf;
      `TGC_CS_GT1_OVF:  selClock = (INSTANCE != 1) & gatedTimerOvf[0];
      `TGC_CS_GT2_OVF:  selClock = (INSTANCE != 2) & gatedTimerOvf[1];
      `TGC_CS_GT3_OVF:  selClock = (INSTANCE != 3) & gatedTimerOvf[2];
      `TGC_CS_LC4:      selClock = logicCellOut[3];
      `TGC_CS_LC3:      selClock = logicCellOut[2];
      `TGC_CS_LC2:      selClock = logicCellOut[1];
      `TGC_CS_LC1:      selClock = logicCellOut[0];
      default:          selClock = 1'b0;
    endcase
  end

  // polarity makes the active level high; toggle mode substitutes the flip-flop
  wire activeGate  = gatePolarity_reg ? rawGate : ~rawGate;
  wire shapedGate  = gateToggleMode_reg ? toggleFf_reg : activeGate;
  wire activeRise  = activeGate & ~gatePrev_reg;
  reg  shapedPrev_reg;
  wire shapedRise  = shapedGate & ~shapedPrev_reg;
  wire shapedFall  = ~shapedGate & shapedPrev_reg;
  // single-pulse gate is open only in the open state
  wire finalGate   = gateSinglePulseMode_reg ? (spState_reg == SP_OPEN) & shapedGate
                                             : shapedGate;

  // bus write strobe: both halves held, lane 0 carries the 8-bit fields
  wire        doWrite  = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  wire [12:0] wIdx     = addrIndex(awAddr_reg);
  wire        wrLane   = doWrite & wLane0_reg;
  wire        wrGCtrl  = wrLane & (wIdx == {1'b0, `TGC_IDX_GATE_CTRL});
  wire        wrTCtrl  = wrLane & (wIdx == {1'b0, `TGC_IDX_TIMER_CTRL});
  wire        wrGSrc   = wrLane & (wIdx == {1'b0, `TGC_IDX_GATE_SRC});
  wire        wrCSrc   = wrLane & (wIdx == {1'b0, `TGC_IDX_CLK_SRC});
  wire        wrMask   = wrLane & (wIdx == {1'b0, `TGC_IDX_IRQ_MASK});
  wire        newSpm   = wrGCtrl ? wData_reg[`TGC_BIT_GATE_SINGLE_PULSE_MODE] : gateSinglePulseMode_reg;
  wire        armReq   = wrGCtrl & wData_reg[`TGC_BIT_GODONE] & newSpm;

  // read strobe
  wire        doRead   = s_axi_arvalid & s_axi_arready;
  wire [12:0] rIdx     = addrIndex(s_axi_araddr);
  wire        rdStatus = doRead & (rIdx == {1'b0, `TGC_IDX_IRQ_STATUS});

  // single-pulse sequencing
  wire spDone = gateSinglePulseMode_reg & (spState_reg == SP_OPEN) & shapedFall;
  reg [1:0] spState_next;
  always @* begin
    spState_next = spState_reg;
    case (spState_reg)
      SP_IDLE:  if (armReq) spState_next = SP_ARMED;
      SP_ARMED: if (shapedRise) spState_next = SP_OPEN;
      SP_OPEN:  if (shapedFall) spState_next = SP_IDLE;
      default:  spState_next = SP_IDLE;
    endcase
    if (!newSpm) spState_next = SP_IDLE;
    else if (armReq && spState_reg == SP_IDLE) spState_next = SP_ARMED;
  end

  // gate path and control fields; reset clears them all, writes keep the rest
  always @(posedge clock or negedge rstN_reg) begin
    if (!rstN_reg) begin
      timerOn_reg             <= 1'b0;
      gateEnable_reg          <= 1'b0;
      gatePolarity_reg        <= 1'b0;
      gateToggleMode_reg      <= 1'b0;
      gateSinglePulseMode_reg <= 1'b0;
      singlePulseGoDone_reg   <= 1'b0;
      gateSourceCode_reg      <= `TGC_RST_SEL;
      clockSourceCode_reg     <= `TGC_RST_SEL;
      toggleFf_reg            <= 1'b0;
      gatePrev_reg            <= 1'b0;
      shapedPrev_reg          <= 1'b0;
      spState_reg             <= SP_IDLE;
      gateLive_reg            <= 1'b0;
    end else begin
      gatePrev_reg   <= activeGate;
      shapedPrev_reg <= shapedGate;
      gateLive_reg   <= finalGate;
      spState_reg    <= spState_next;
      if (wrTCtrl) timerOn_reg <= wData_reg[`TGC_BIT_ON];
      if (wrGCtrl) begin
        gateEnable_reg          <= wData_reg[`TGC_BIT_GE];
        gatePolarity_reg        <= wData_reg[`TGC_BIT_GATE_POLARITY];
        gateToggleMode_reg      <= wData_reg[`TGC_BIT_GTM];
        gateSinglePulseMode_reg <= wData_reg[`TGC_BIT_GATE_SINGLE_PULSE_MODE];
      end
      if (wrGSrc) gateSourceCode_reg <= wData_reg[4:0];
      if (wrCSrc) clockSourceCode_reg <= wData_reg[4:0];
      // toggle mode off holds the flip-flop cleared
      if (wrGCtrl && !wData_reg[`TGC_BIT_GTM])
        toggleFf_reg <= 1'b0;
      else if (!gateToggleMode_reg)
        toggleFf_reg <= 1'b0;
      else if (activeRise)
        toggleFf_reg <= ~toggleFf_reg;
      // arming wins over completion in the same cycle; mode off always clears
      if (!newSpm)
        singlePulseGoDone_reg <= 1'b0;
      else if (armReq)
        singlePulseGoDone_reg <= 1'b1;
      else if (spDone)
        singlePulseGoDone_reg <= 1'b0;
    end
  end

  // outputs to the counter, registered
  always @(posedge clock or negedge rstN_reg) begin
    if (!rstN_reg) begin
      timerGateEnable <= 1'b0;
      countClock      <= 1'b0;
    end else begin
      timerGateEnable <= timerOn_reg & (~gateEnable_reg | finalGate);
      countClock      <= selClock;
    end
  end

  // sticky events; a read clears, but a new event in that cycle survives
  wire       gateOpenEvt = finalGate & ~gateLive_reg;
  wire [1:0] irqEvents   = {gateOpenEvt, spDone};
  always @(posedge clock or negedge rstN_reg) begin
    if (!rstN_reg) begin
      irqStatus_reg <= `TGC_RST_IRQ;
      irqMask_reg   <= `TGC_RST_IRQ;
      irq           <= 1'b0;
    end else begin
      irqStatus_reg <= (rdStatus ? 2'h0 : irqStatus_reg) | irqEvents;
      if (wrMask) irqMask_reg <= wData_reg[1:0];
      irq <= |(((rdStatus ? 2'h0 : irqStatus_reg) | irqEvents) & irqMask_reg);
    end
  end

  // write channel: address and data taken in either order, answer after both
  always @(posedge clock or negedge rstN_reg) begin
    if (!rstN_reg) begin
      awHeld_reg    <= 1'b0;
      wHeld_reg     <= 1'b0;
      awAddr_reg    <= 12'h000;
      wData_reg     <= 32'h00000000;
      wLane0_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TGC_RESP_OKAY;
    end else begin
      s_axi_awready <= ~awHeld_reg & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~wHeld_reg & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg  <= 1'b1;
        wData_reg  <= s_axi_wdata;
        wLane0_reg <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(wIdx) ? `TGC_RESP_OKAY : `TGC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data mux; reserved bits read zero
  reg [31:0] rMux;
  always @* begin
    rMux = 32'h00000000;
    if (rIdx == {1'b0, `TGC_IDX_TIMER_CTRL})
      rMux[`TGC_BIT_ON] = timerOn_reg;
    else if (rIdx == {1'b0, `TGC_IDX_GATE_CTRL}) begin
      rMux[`TGC_BIT_GE]     = gateEnable_reg;
      rMux[`TGC_BIT_GATE_POLARITY]   = gatePolarity_reg;
      rMux[`TGC_BIT_GTM]    = gateToggleMode_reg;
      rMux[`TGC_BIT_GATE_SINGLE_PULSE_MODE]   = gateSinglePulseMode_reg;
      rMux[`TGC_BIT_GODONE] = singlePulseGoDone_reg;
      rMux[`TGC_BIT_GATE_CURRENT_VALUE]   = gateLive_reg;
    end else if (rIdx == {1'b0, `TGC_IDX_GATE_SRC})
      rMux[4:0] = gateSourceCode_reg;
    else if (rIdx == {1'b0, `TGC_IDX_CLK_SRC})
      rMux[4:0] = clockSourceCode_reg;
    else if (rIdx == {1'b0, `TGC_IDX_IRQ_STATUS})
      rMux[1:0] = irqStatus_reg;
    else if (rIdx == {1'b0, `TGC_IDX_IRQ_MASK})
      rMux[1:0] = irqMask_reg;
  end

  // read channel: one outstanding read, answer one cycle after acceptance
  always @(posedge clock or negedge rstN_reg) begin
    if (!rstN_reg) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `TGC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~doRead;
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rMux;
        s_axi_rresp  <= isMapped(rIdx) ? `TGC_RESP_OKAY : `TGC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // tgc_gate_select

/* File: rtl/tgc_consts.vh */
`ifndef TGC_CONSTS_VH
`define TGC_CONSTS_VH

// register indices; byte address is four times the index
`define TGC_IDX_TIMER_CTRL   12'h20E
`define TGC_IDX_GATE_CTRL    12'h20F
`define TGC_IDX_GATE_SRC     12'h210
`define TGC_IDX_CLK_SRC      12'h211
`define TGC_IDX_IRQ_STATUS   12'h220
`define TGC_IDX_IRQ_MASK     12'h221

// timer control fields
`define TGC_BIT_ON           0

// gate control fields
`define TGC_BIT_GE           7
`define TGC_BIT_GATE_POLARITY         6
`define TGC_BIT_GTM          5
`define TGC_BIT_GATE_SINGLE_PULSE_MODE         4
`define TGC_BIT_GODONE       3
`define TGC_BIT_GATE_CURRENT_VALUE         2

// interrupt status and mask fields
`define TGC_IRQ_SP_DONE      0
`define TGC_IRQ_GATE_OPEN    1
`define TGC_IRQ_W            2

// reset values
`define TGC_RST_SEL          5'h00
`define TGC_RST_CTRL         8'h00
`define TGC_RST_IRQ          2'h0

// gate source codes
`define TGC_GS_PIN           5'h00
`define TGC_GS_BASE_OVF      5'h01
`define TGC_GS_GT1_OVF       5'h02
`define TGC_GS_PT1_POST      5'h03
`define TGC_GS_GT2_OVF       5'h04
`define TGC_GS_PT2_POST      5'h05
`define TGC_GS_GT3_OVF       5'h06
`define TGC_GS_PT3_POST      5'h07
`define TGC_GS_SMT_OVF       5'h08
`define TGC_GS_CCP1          5'h09
`define TGC_GS_CCP2          5'h0A
`define TGC_GS_CCP3          5'h0B
`define TGC_GS_CCP4          5'h0C
`define TGC_GS_PWM1          5'h0D
`define TGC_GS_PWM2          5'h0E
`define TGC_GS_NCO           5'h0F
`define TGC_GS_CMP1          5'h10
`define TGC_GS_CMP2          5'h11
`define TGC_GS_ZCD           5'h12
`define TGC_GS_LC1           5'h13
`define TGC_GS_LC2           5'h14
`define TGC_GS_LC3           5'h15
`define TGC_GS_LC4           5'h16

// clock source codes
`define TGC_CS_PIN           5'h00
`define TGC_CS_INSTR         5'h01
`define TGC_CS_SYS           5'h02
`define TGC_CS_HFOSC         5'h03
`define TGC_CS_LFOSC         5'h04
`define TGC_CS_MF500K        5'h05
`define TGC_CS_MF32K         5'h06
`define TGC_CS_SECONDARY_OSCILLATOR          5'h07
`define TGC_CS_REFCLK        5'h08
`define TGC_CS_BASE_OVF      5'h09
`define TGC_CS_GT1_OVF       5'h0A
`define TGC_CS_GT2_OVF       5'h0B
`define TGC_CS_GT3_OVF       5'h0C
`define TGC_CS_LC1           5'h0D
`define TGC_CS_LC2           5'h0E
`define TGC_CS_LC3           5'h0F
`define TGC_CS_LC4           5'h10

// bus responses
`define TGC_RESP_OKAY        2'h0
`define TGC_RESP_SLVERR      2'h2

`endif

/* File: dv/tgc_gate_select_monitor.sv */
`timescale 1ns/100ps
// bus handshakes and reset release, seen from the block's pins only
module tgc_gate_select_monitor (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // both write halves meet in one cycle, or a read address is taken
  sequence sWrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sRdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (sWrTaken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_answer: assert property (sRdTaken |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  // sync flops still hold the block quiet just after release
  a_reset_quiet: assert property ($rose(nrst) |-> !s_axi_awready && !s_axi_arready ##1 !s_axi_awready)
    else $error("ready too soon after reset");
endmodule // tgc_gate_select_monitor

bind tgc_gate_select tgc_gate_select_monitor tgc_gate_select_monitor_inst (
  .clock(clock), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

/* File: dv/tgc_sources.sv */
`timescale 1ns/100ps
// pins, oscillators and peers: the picked line carries lvl, all others
// its inverse, so a wrong pick by the block shows as a wrong level
module tgc_sources (
  input  wire logic [4:0]  code,
  input  wire logic        isClk,
  input  wire logic        lvl,
  output logic      [31:0] src
);
  int pos;
  // select code to the src bit that feeds that design input
  always_comb begin
    pos = 32;
    if (isClk) begin
      if (code < 9) pos = code + 23;
      else if (code < 13) pos = code - 8;
      else if (code < 17) pos = code + 6;
    end else if (code < 8) pos = code < 2 ? code : code / 2 + (code[0] ? 4 : 1);
    else if (code < 23) pos = code;
  end
  // reserved codes leave every line at the inverse level
  assign src = {32{~lvl}} ^ (pos < 32 ? 32'h1 << pos : 32'h0);
endmodule // tgc_sources

/* File: dv/tgc_gate_select_test.sv */
`timescale 1ns/100ps
`include "tgc_consts.vh"
module tgc_gate_select_test;
  logic        clock, nrst, awValid, wValid, bReady, arValid, rReady, isClk, lvl;
  logic        awReady, wReady, bValid, arReady, rValid, gate, cclk, irq;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, rData, src;
  logic [1:0]  bResp, rResp, r;
  logic [7:0]  v;
  logic [4:0]  code;
  int          failures, checked;

  tgc_sources tgc_sources_inst (.code(code), .isClk(isClk), .lvl(lvl), .src(src));
  tgc_gate_select #(.INSTANCE(1)) tgc_gate_select_inst (
    .clock(clock), .nrst(nrst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .remappableGatePin(src[0]), .baseTimerOvf(src[1]), .gatedTimerOvf(src[4:2]),
    .periodTimerPostscaled(src[7:5]), .signalMeasureOverflow(src[8]),
    .captureCompareOut(src[12:9]), .pwmUnitOut(src[14:13]), .numericOscillatorOut(src[15]),
    .comparatorSyncOut(src[17:16]), .zeroCrossOut(src[18]), .logicCellOut(src[22:19]),
    .remappableClockPin(src[23]), .instrClock(src[24]), .sysClock(src[25]),
    .highFreqInternalOsc(src[26]), .lowFreqInternalOsc(src[27]),
    .midFreqInternalOsc500k(src[28]), .midFreqInternalOsc32k(src[29]),
    .secondaryOscillator(src[30]), .referenceClockOut(src[31]), .timerGateEnable(gate),
    .countClock(cclk), .irq(irq));

  // 200 MHz
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // response ready raised a cycle late so the held response is exercised
  task automatic wr(logic [11:0] idx, logic [7:0] d);
    awAddr <= idx << 2;
    wData <= {24'h0, d};
    awValid <= 1'h1;
    wValid <= 1'h1;
    forever begin
      @(posedge clock);
      if (awValid && awReady) awValid <= 1'h0;
      if (wValid && wReady) wValid <= 1'h0;
      if (bValid && bReady) break;
      if (bValid) bReady <= 1'h1;
    end
    r = bResp;
    bReady <= 1'h0;
    @(posedge clock);
  endtask

  task automatic rd(logic [11:0] idx);
    arAddr <= idx << 2;
    arValid <= 1'h1;
    forever begin
      @(posedge clock);
      if (arValid && arReady) arValid <= 1'h0;
      if (rValid && rReady) break;
      if (rValid) rReady <= 1'h1;
    end
    v = rData[7:0];
    r = rResp;
    rReady <= 1'h0;
    @(posedge clock);
  endtask

  // gate and clock paths settle within two cycles, four is margin
  task automatic setl(logic x);
    lvl <= x;
    repeat (4) @(posedge clock);
  endtask

  task automatic end_sim;
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // a hung handshake ends the run
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    end_sim;
  end

  initial begin
    {awValid, wValid, bReady, arValid, rReady, isClk, lvl, nrst} = 8'h00;
    {awAddr, arAddr, wData, code} = '0;
    failures = 0;
    checked = 0;
    repeat (3) @(posedge clock);
    nrst <= 1'h1;
    repeat (4) @(posedge clock);
    rd(`TGC_IDX_GATE_SRC);
    chk("gate sel", 8'h00, v);
    rd(`TGC_IDX_CLK_SRC);
    chk("clock sel", 8'h00, v);
    rd(`TGC_IDX_GATE_CTRL);
    chk("gate ctrl", 8'h00, v & 8'hFB);
    rd(12'h001);
    chk("unmapped", 10'h200, {r, v});
    wr(12'h001, 8'hFF);
    chk("unmapped wr", 2'h2, r);
    // every gate then clock code, picked line high then low
    wr(`TGC_IDX_TIMER_CTRL, 8'h01);
    chk("write resp", 2'h0, r);
    wr(`TGC_IDX_GATE_CTRL, 8'hC0);
    for (int k = 0; k < 64; k++) begin
      isClk <= k[5];
      code <= k[4:0];
      wr(k[5] ? `TGC_IDX_CLK_SRC : `TGC_IDX_GATE_SRC, {3'h0, k[4:0]});
      for (int l = 1; l >= 0; l--) begin
        setl(l[0]);
        if (k[5]) chk("clock", l[0] && k[4:0] < 17 && k[4:0] != 10, cclk);
        else chk("gate", l[0] && k < 23 && k != 2, gate);
      end
    end
    // polarity, then gate enable off with the live value still visible
    isClk <= 1'h0;
    // back to the pin code so the pin line carries lvl again
    code <= 5'h00;
    wr(`TGC_IDX_GATE_SRC, 8'h00);
    wr(`TGC_IDX_GATE_CTRL, 8'h80);
    setl(1'h1);
    chk("active low", 1'h0, gate);
    wr(`TGC_IDX_GATE_CTRL, 8'h40);
    for (int l = 0; l < 2; l++) begin
      setl(l[0]);
      rd(`TGC_IDX_GATE_CTRL);
      chk("free run", 1'h1, gate);
      chk("gate value", l[0], v[2]);
    end
    // toggle flips on a rising edge; leaving toggle mode must clear it
    wr(`TGC_IDX_GATE_CTRL, 8'hE0);
    setl(1'h0);
    setl(1'h1);
    setl(1'h0);
    chk("toggle", 1'h1, gate);
    wr(`TGC_IDX_GATE_CTRL, 8'hC0);
    wr(`TGC_IDX_GATE_CTRL, 8'hE0);
    setl(1'h0);
    chk("toggle clear", 1'h0, gate);
    // single pulse: nothing until armed, then one window only
    wr(`TGC_IDX_GATE_CTRL, 8'hD0);
    rd(`TGC_IDX_IRQ_STATUS);
    setl(1'h1);
    chk("unarmed", 1'h0, gate);
    rd(`TGC_IDX_GATE_CTRL);
    chk("idle done", 1'h0, v[3]);
    setl(1'h0);
    wr(`TGC_IDX_GATE_CTRL, 8'hD8);
    rd(`TGC_IDX_GATE_CTRL);
    chk("armed", 1'h1, v[3]);
    setl(1'h1);
    chk("pulse open", 1'h1, gate);
    setl(1'h0);
    rd(`TGC_IDX_GATE_CTRL);
    chk("pulse done", 8'hD0, v);
    setl(1'h1);
    chk("one pulse", 1'h0, gate);
    // events wait in status until read; the line follows the mask
    chk("irq masked", 1'h0, irq);
    wr(`TGC_IDX_IRQ_MASK, 8'h03);
    chk("irq raised", 1'h1, irq);
    rd(`TGC_IDX_IRQ_STATUS);
    chk("status", 8'h03, v);
    chk("irq cleared", 1'h0, irq);
    wr(`TGC_IDX_GATE_CTRL, 8'hD8);
    wr(`TGC_IDX_GATE_CTRL, 8'hC0);
    rd(`TGC_IDX_GATE_CTRL);
    chk("disarmed", 1'h0, v[3]);
    // with the timer off the gate enable bit is ignored and nothing counts
    chk("gate open", 1'h1, gate);
    wr(`TGC_IDX_TIMER_CTRL, 8'h00);
    setl(1'h1);
    chk("timer off", 1'h0, gate);
    end_sim;
  end
endmodule // tgc_gate_select_test
